//--- bench/irf_cpu_model.sv
`timescale 1ns/100ps

module irf_cpu_model
  import irf_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  input  wire logic              slow,
  input  wire logic [DATA_W-1:0] edge_req_q,
  input  wire logic [DATA_W-1:0] timer_lvl_req_q,
  input  wire logic [DATA_W-1:0] periph_req_q,
  output int                     accepts
);
  int wait_q;

  // Accepts a pending request after a short or long wait; never clears it
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      wait_q  <= 0;
      accepts <= 0;
    end else if (|{edge_req_q, timer_lvl_req_q, periph_req_q}) begin
      wait_q <= wait_q + 1;
      if (wait_q == (slow ? 7 : 1)) begin
        accepts <= accepts + 1;
        wait_q  <= 0;
      end
    end
  end
endmodule // irf_cpu_model

//--- bench/irf_flag_bank_asserts.sv
`timescale 1ns/100ps

module irf_flag_bank_asserts
  import irf_pkg::*;
(
  input wire logic                ref_clk,
  input wire logic                reset_n,
  input wire irf_bus_req_t        bus_req,
  input wire logic [DATA_W-1:0]   reg_rdata_q,
  input wire irf_periph_ev_t      periph_ev,
  input wire logic                direct_transfer_enable,
  input wire logic                converter_start_flag,
  input wire logic [LVL_PINS-1:0] level_request_pin,
  input wire logic [LVL_PINS-1:0] level_pin_is_irq,
  input wire logic [LVL_PINS-1:0] level_pin_polarity,
  input wire logic [DATA_W-1:0]   edge_request_pin,
  input wire logic [DATA_W-1:0]   edge_req_q,
  input wire logic [DATA_W-1:0]   timer_lvl_req_q,
  input wire logic [DATA_W-1:0]   periph_req_q,
  input wire logic                irq_q
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // -----------------------------
  // Register port
  // -----------------------------
  property p_en_rw;
    bus_req.wr && bus_req.addr == OFS_EDGE_EN ##1
      bus_req.rd && bus_req.addr == OFS_EDGE_EN
      |=> reg_rdata_q == $past(bus_req.wdata, 2);
  endproperty
  a_en_rw: assert property (p_en_rw)
    else $error("enable readback wrong");

  property p_rsv1;
    bus_req.rd && bus_req.addr == OFS_TIMER_LVL |=> reg_rdata_q[5:4] == 2'b01;
  endproperty
  a_rsv1: assert property (p_rsv1)
    else $error("reserved bits of first register wrong");

  property p_rsv2;
    bus_req.rd && bus_req.addr == OFS_PERIPH
      |=> (reg_rdata_q & 8'h2f) == 8'h00;
  endproperty
  a_rsv2: assert property (p_rsv2)
    else $error("reserved bits of second register wrong");

  // -----------------------------
  // Flag setting and holding
  // -----------------------------
  property p_tb1;
    periph_ev.timer_b1_wrap |=> timer_lvl_req_q[B_TIMER_B1];
  endproperty
  a_tb1: assert property (p_tb1)
    else $error("timer b1 flag not set");

  property p_ta;
    periph_ev.timer_a_wrap |=> timer_lvl_req_q[B_TIMER_A];
  endproperty
  a_ta: assert property (p_ta)
    else $error("timer a flag not set");

  property p_dir;
    periph_ev.direct_sleep && direct_transfer_enable
      |=> periph_req_q[B_DIRECT];
  endproperty
  a_dir: assert property (p_dir)
    else $error("direct transfer flag not set");

  property p_conv;
    $past(reset_n) && $fell(converter_start_flag) |=> periph_req_q[B_CONV];
  endproperty
  a_conv: assert property (p_conv)
    else $error("conversion flag not set");

  property p_ser;
    periph_ev.serial1_done |=> periph_req_q[B_SERIAL1];
  endproperty
  a_ser: assert property (p_ser)
    else $error("serial flag not set");

  property p_sticky;
    !(bus_req.wr && bus_req.addr == OFS_TIMER_LVL)
      |=> (timer_lvl_req_q & $past(timer_lvl_req_q))
          == $past(timer_lvl_req_q);
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("flag cleared without write");

  // Main scenarios reached
  c_irq: cover property ($rose(irq_q));
  c_clash: cover property (periph_ev.serial1_done && bus_req.wr);
  c_edge: cover property (edge_req_q != 8'h00);
endmodule // irf_flag_bank_asserts

//--- bench/tb_irf_flag_bank.sv
`timescale 1ns/100ps

module tb_irf_flag_bank;
  import irf_pkg::*;
  logic                ref_clk;
  logic                reset_n;
  irf_bus_req_t        bus_req;
  logic [DATA_W-1:0]   reg_rdata_q;
  irf_periph_ev_t      periph_ev;
  logic                direct_transfer_enable;
  logic                converter_start_flag;
  logic [LVL_PINS-1:0] level_request_pin;
  logic [LVL_PINS-1:0] level_pin_is_irq;
  logic [LVL_PINS-1:0] level_pin_polarity;
  logic [DATA_W-1:0]   edge_request_pin;
  logic [DATA_W-1:0]   edge_req_q;
  logic [DATA_W-1:0]   timer_lvl_req_q;
  logic [DATA_W-1:0]   periph_req_q;
  logic                irq_q;
  logic                slow;
  int                  accepts;
  int                  err_count;
  int                  checks_done;
  int                  i;
  logic [DATA_W-1:0]   en, pol, fl, pv, nv;

  irf_flag_bank i_irf_flag_bank (
    .ref_clk, .reset_n, .bus_req, .reg_rdata_q, .periph_ev,
    .direct_transfer_enable, .converter_start_flag, .level_request_pin,
    .level_pin_is_irq, .level_pin_polarity, .edge_request_pin,
    .edge_req_q, .timer_lvl_req_q, .periph_req_q, .irq_q
  );

  irf_cpu_model i_irf_cpu_model (
    .ref_clk, .reset_n, .slow, .edge_req_q, .timer_lvl_req_q,
    .periph_req_q, .accepts
  );

  // Clock and watchdog
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    results;
  end

  // -----------------------------
  // Helpers
  // -----------------------------
  function automatic logic [DATA_W-1:0] edges(input logic [DATA_W-1:0] p,
                                              c, s);
    return (p & ~c & ~s) | (~p & c & s);
  endfunction

  task automatic chk(input logic [DATA_W-1:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v,
                    input bit hold = 1'b0);
    bus_req <= '{a, v, 1'b1, 1'b0};
    @(posedge ref_clk);
    if (!hold) begin
      bus_req <= '0;
      @(posedge ref_clk);
    end
  endtask

  task automatic rc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge ref_clk);
    bus_req <= '0;
    #1 chk(reg_rdata_q, e);
    @(posedge ref_clk);
  endtask

  task automatic ev(input irf_periph_ev_t e);
    periph_ev <= e;
    tick(1);
    periph_ev <= '0;
    tick(1);
  endtask

  task results;
    $display("Checks %0d, errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // -----------------------------
  // Main sequence
  // -----------------------------
  initial begin
    reset_n = 1'b0;
    bus_req = '0;
    periph_ev = '0;
    direct_transfer_enable = 1'b0;
    converter_start_flag = 1'b0;
    level_request_pin = 4'hf;
    level_pin_is_irq = 4'h0;
    level_pin_polarity = 4'h0;
    edge_request_pin = 8'hff;
    slow = 1'b0;
    err_count = 0;
    checks_done = 0;
    void'($urandom(69));
    tick(8);
    reset_n <= 1'b1;
    tick(1);
    rc(OFS_EDGE_EN, 8'h00);
    rc(OFS_TIMER_LVL, 8'h10);
    rc(OFS_PERIPH, 8'h00);
    rc(OFS_EDGE_FLAGS, 8'h00);
    rc(4'hf, 8'h00);
    for (i = 0; i < 3; i++) begin
      en = 8'($urandom);
      wr(OFS_EDGE_EN, en, 1'b1);
      rc(OFS_EDGE_EN, en);
    end
    $display("test registers done");
    ev(4'h8);
    ev(4'h4);
    rc(OFS_TIMER_LVL, 8'hd0);
    wr(OFS_TIMER_LVL, 8'hff);
    rc(OFS_TIMER_LVL, 8'hd0);
    wr(OFS_TIMER_LVL, 8'h7f);
    rc(OFS_TIMER_LVL, 8'h50);
    wr(OFS_PERIPH, 8'hff);
    rc(OFS_PERIPH, 8'h00);
    slow <= 1'b1;
    tick(12);
    chk(8'(accepts != 0), 8'h01);
    rc(OFS_TIMER_LVL, 8'h50);
    chk(8'(irq_q), 8'h00);
    rc(OFS_IRQ_STATUS, 8'h02);
    wr(OFS_IRQ_MASK, 8'h02);
    rc(OFS_IRQ_MASK, 8'h02);
    chk(8'(irq_q), 8'h01);
    wr(OFS_IRQ_STATUS, 8'h0f);
    rc(OFS_IRQ_STATUS, 8'h00);
    chk(8'(irq_q), 8'h00);
    wr(OFS_TIMER_LVL, 8'h00);
    $display("test timers and irq done");
    ev(4'h2);
    rc(OFS_PERIPH, 8'h00);
    direct_transfer_enable <= 1'b1;
    ev(4'h2);
    converter_start_flag <= 1'b1;
    tick(2);
    converter_start_flag <= 1'b0;
    ev(4'h1);
    rc(OFS_PERIPH, 8'hd0);
    chk(periph_req_q, 8'hd0);
    wr(OFS_PERIPH, 8'h00);
    periph_ev <= 4'h1;
    bus_req <= '{OFS_PERIPH, 8'h00, 1'b1, 1'b0};
    tick(1);
    periph_ev <= '0;
    bus_req <= '0;
    tick(1);
    rc(OFS_PERIPH, 8'h10);
    $display("test peripherals done");
    level_request_pin <= 4'h0;
    tick(2);
    level_request_pin <= 4'hf;
    tick(2);
    rc(OFS_TIMER_LVL, 8'h10);
    level_pin_is_irq <= 4'hf;
    for (i = 0; i < LVL_PINS; i++) begin
      pv[0] = 1'($urandom);
      level_pin_polarity[i] <= pv[0];
      level_request_pin[i] <= ~pv[0];
      tick(2);
      level_request_pin[i] <= pv[0];
      tick(2);
    end
    rc(OFS_TIMER_LVL, 8'h1f);
    chk(timer_lvl_req_q, 8'h0f);
    $display("test level pins done");
    pol = 8'($urandom);
    wr(OFS_EDGE_POL, pol);
    fl = 8'h00;
    pv = 8'hff;
    for (i = 0; i < 8; i++) begin
      nv = (i == 0) ? ~pol : 8'($urandom);
      edge_request_pin <= nv;
      fl = fl | edges(pv, nv, pol);
      pv = nv;
      tick(2);
    end
    chk(edge_req_q, fl & en);
    rc(OFS_EDGE_POL, pol);
    rc(OFS_EDGE_FLAGS, fl);
    wr(OFS_EDGE_FLAGS, 8'hf0);
    rc(OFS_EDGE_FLAGS, fl & 8'hf0);
    $display("test edge pins done");
    results;
  end
endmodule // tb_irf_flag_bank

bind irf_flag_bank irf_flag_bank_asserts i_irf_flag_bank_asserts (
  .ref_clk, .reset_n, .bus_req, .reg_rdata_q, .periph_ev,
  .direct_transfer_enable, .converter_start_flag, .level_request_pin,
  .level_pin_is_irq, .level_pin_polarity, .edge_request_pin,
  .edge_req_q, .timer_lvl_req_q, .periph_req_q, .irq_q
);

//--- hdl/irf_edge_detect.sv
`timescale 1ns/100ps

module irf_edge_detect
  import irf_pkg::*;
#(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] pin,
  input  wire logic [WIDTH-1:0] rising_sel,
  output logic      [WIDTH-1:0] edge_seen
);

  // ---------------------------------------------------------------
  // Previous pin level
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] prev_q;
  logic             primed_q;

  // Capture last level; first cycle after reset only primes
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      prev_q   <= '0;
      primed_q <= 1'b0;
    end else begin
      prev_q   <= pin;
      primed_q <= 1'b1;
    end
  end

  // Select falling (0) or rising (1) per bit
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      if (rising_sel[i]) begin
        edge_seen[i] = primed_q & pin[i] & ~prev_q[i];
      end else begin
        edge_seen[i] = primed_q & ~pin[i] & prev_q[i];
      end
    end
  end

endmodule // irf_edge_detect

//--- hdl/irf_flag_bank.sv
`timescale 1ns/100ps


module irf_flag_bank
  import irf_pkg::*;
(
  input  wire logic                  ref_clk,
  input  wire logic                  reset_n,
  // Register port
  input  wire irf_bus_req_t          bus_req,
  output logic        [DATA_W-1:0]   reg_rdata_q,
  // Event sources
  input  wire irf_periph_ev_t        periph_ev,
  input  wire logic                  direct_transfer_enable,
  input  wire logic                  converter_start_flag,
  input  wire logic   [LVL_PINS-1:0] level_request_pin,
  input  wire logic   [LVL_PINS-1:0] level_pin_is_irq,
  input  wire logic   [LVL_PINS-1:0] level_pin_polarity,
  input  wire logic   [DATA_W-1:0]   edge_request_pin,
  // Requests toward the CPU core
  output logic        [DATA_W-1:0]   edge_req_q,
  output logic        [DATA_W-1:0]   timer_lvl_req_q,
  output logic        [DATA_W-1:0]   periph_req_q,
  output logic                       irq_q
);

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] edge_pin_irq_enable_q;
  logic [DATA_W-1:0] edge_pin_polarity_select_q;
  logic [DATA_W-1:0] timer_and_level_pin_request_flags_q;
  logic [DATA_W-1:0] timer_and_level_pin_request_flags_d;
  logic [DATA_W-1:0] peripheral_request_flags_q;
  logic [DATA_W-1:0] peripheral_request_flags_d;
  logic [DATA_W-1:0] edge_pin_request_flags_q;
  logic [DATA_W-1:0] edge_pin_request_flags_d;
  logic [EV_W-1:0]   irq_status_q;
  logic [EV_W-1:0]   irq_status_d;
  logic [EV_W-1:0]   irq_mask_q;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  logic wr_edge_en;
  logic wr_timer_lvl;
  logic wr_periph;
  logic wr_edge_flags;
  logic wr_edge_pol;
  logic wr_status;
  logic wr_mask;

  // One-cycle write selects per register
  assign wr_edge_en    = bus_req.wr && (bus_req.addr == OFS_EDGE_EN);
  assign wr_timer_lvl  = bus_req.wr && (bus_req.addr == OFS_TIMER_LVL);
  assign wr_periph     = bus_req.wr && (bus_req.addr == OFS_PERIPH);
  assign wr_edge_flags = bus_req.wr && (bus_req.addr == OFS_EDGE_FLAGS);
  assign wr_edge_pol   = bus_req.wr && (bus_req.addr == OFS_EDGE_POL);
  assign wr_status     = bus_req.wr && (bus_req.addr == OFS_IRQ_STATUS);
  assign wr_mask       = bus_req.wr && (bus_req.addr == OFS_IRQ_MASK);

  // ---------------------------------------------------------------
  // Event detection
  // ---------------------------------------------------------------
  logic [LVL_PINS-1:0] level_edge;
  logic [DATA_W-1:0]   edge_pin_edge;
  logic                conv_busy_q;
  logic                conv_primed_q;
  logic                conv_done;

  // Level request pins, polarity from outside select
  irf_edge_detect #(
    .WIDTH      (LVL_PINS)
  ) u_level_edge (
    .ref_clk    (ref_clk),
    .reset_n    (reset_n),
    .pin        (level_request_pin),
    .rising_sel (level_pin_polarity),
    .edge_seen  (level_edge)
  );

  // Edge request pins, polarity from own select register
  irf_edge_detect #(
    .WIDTH      (DATA_W)
  ) u_pin_edge (
    .ref_clk    (ref_clk),
    .reset_n    (reset_n),
    .pin        (edge_request_pin),
    .rising_sel (edge_pin_polarity_select_q),
    .edge_seen  (edge_pin_edge)
  );

  // Track converter busy to see its fall
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      conv_busy_q   <= 1'b0;
      conv_primed_q <= 1'b0;
    end else begin
      conv_busy_q   <= converter_start_flag;
      conv_primed_q <= 1'b1;
    end
  end

  // Conversion finished: busy flag returned to 0
  assign conv_done = conv_primed_q & conv_busy_q
                     & ~converter_start_flag;

  // ---------------------------------------------------------------
  // Set and clear vectors
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] set_timer_lvl;
  logic [DATA_W-1:0] set_periph;
  logic [DATA_W-1:0] set_edge;
  logic [DATA_W-1:0] clr_timer_lvl;
  logic [DATA_W-1:0] clr_periph;
  logic [DATA_W-1:0] clr_edge;

  // Hardware set sources for the first request register
  always_comb begin
    set_timer_lvl             = '0;
    set_timer_lvl[B_TIMER_B1] = periph_ev.timer_b1_wrap;
    set_timer_lvl[B_TIMER_A]  = periph_ev.timer_a_wrap;
    set_timer_lvl[LVL_PINS-1:0] =
      level_edge & level_pin_is_irq;
  end

  // Hardware set sources for the second request register
  always_comb begin
    set_periph            = '0;
    set_periph[B_DIRECT]  = periph_ev.direct_sleep
                            & direct_transfer_enable;
    set_periph[B_CONV]    = conv_done;
    set_periph[B_SERIAL1] = periph_ev.serial1_done;
  end

  // Edge pins flag regardless of port or interrupt use
  assign set_edge = edge_pin_edge;

  // Clears come only from written zeros; ones do nothing
  assign clr_timer_lvl = wr_timer_lvl
    ? (~bus_req.wdata & WMASK_TIMER_LVL) : '0;
  assign clr_periph    = wr_periph
    ? (~bus_req.wdata & WMASK_PERIPH) : '0;
  assign clr_edge      = wr_edge_flags ? ~bus_req.wdata : '0;

  // ---------------------------------------------------------------
  // Flag next state
  // ---------------------------------------------------------------
  // Set ORed after clear so the event wins
  always_comb begin
    timer_and_level_pin_request_flags_d =
      (timer_and_level_pin_request_flags_q & ~clr_timer_lvl)
      | set_timer_lvl;
    timer_and_level_pin_request_flags_d[B_RSV_ZERO] = 1'b0;
    timer_and_level_pin_request_flags_d[B_RSV_ONE]  = 1'b1;
  end

  // Reserved bits forced low by the write mask
  always_comb begin
    peripheral_request_flags_d =
      ((peripheral_request_flags_q & ~clr_periph) | set_periph)
      & WMASK_PERIPH;
  end

  // Edge flags, same set-over-clear ordering
  always_comb begin
    edge_pin_request_flags_d =
      (edge_pin_request_flags_q & ~clr_edge) | set_edge;
  end

  // ---------------------------------------------------------------
  // Request flag registers
  // ---------------------------------------------------------------
  // No acceptance input: flags fall only by software
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      timer_and_level_pin_request_flags_q <= RST_TIMER_LVL;
    end else begin
      timer_and_level_pin_request_flags_q <=
        timer_and_level_pin_request_flags_d;
    end
  end

  // Second request register
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      peripheral_request_flags_q <= RST_PERIPH;
    end else begin
      peripheral_request_flags_q <= peripheral_request_flags_d;
    end
  end

  // Third request register
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      edge_pin_request_flags_q <= RST_EDGE_FLAGS;
    end else begin
      edge_pin_request_flags_q <= edge_pin_request_flags_d;
    end
  end

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  // Edge-pin enable, plain read/write
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      edge_pin_irq_enable_q <= RST_EDGE_EN;
    end else if (wr_edge_en) begin
      edge_pin_irq_enable_q <= bus_req.wdata;
    end
  end

  // Edge polarity select, falling after reset
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      edge_pin_polarity_select_q <= RST_EDGE_POL;
    end else if (wr_edge_pol) begin
      edge_pin_polarity_select_q <= bus_req.wdata;
    end
  end

  // Interrupt mask
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      irq_mask_q <= RST_IRQ;
    end else if (wr_mask) begin
      irq_mask_q <= bus_req.wdata[EV_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // Interrupt status
  // ---------------------------------------------------------------
  logic [EV_W-1:0] ev_now;
  logic [EV_W-1:0] ev_clr;

  // Group events by source family
  always_comb begin
    ev_now            = '0;
    ev_now[EV_EDGE]   = |set_edge;
    ev_now[EV_TIMER]  = |set_timer_lvl[B_TIMER_B1:B_TIMER_A];
    ev_now[EV_LEVEL]  = |set_timer_lvl[LVL_PINS-1:0];
    ev_now[EV_PERIPH] = |set_periph;
  end

  // Write one to clear, new event wins
  assign ev_clr = wr_status ? bus_req.wdata[EV_W-1:0] : '0;
  assign irq_status_d = (irq_status_q & ~ev_clr) | ev_now;

  // Sticky status
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      irq_status_q <= RST_IRQ;
    end else begin
      irq_status_q <= irq_status_d;
    end
  end

  // Level interrupt from unmasked status
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_status_d & irq_mask_q);
    end
  end

  // ---------------------------------------------------------------
  // Requests toward the CPU core
  // ---------------------------------------------------------------
  // Edge pins gated by their enable bits
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      edge_req_q <= '0;
    end else begin
      edge_req_q <= edge_pin_request_flags_d
                    & edge_pin_irq_enable_q;
    end
  end

  // Other flags pass raw; their enables sit in the core
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      timer_lvl_req_q <= '0;
      periph_req_q    <= '0;
    end else begin
      timer_lvl_req_q <= timer_and_level_pin_request_flags_d
                         & WMASK_TIMER_LVL;
      periph_req_q    <= peripheral_request_flags_d;
    end
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] rd_mux;

  // Unmapped indices read zero
  always_comb begin
    rd_mux = '0;
    unique case (bus_req.addr)
      OFS_EDGE_EN:    rd_mux = edge_pin_irq_enable_q;
      OFS_TIMER_LVL:  rd_mux = timer_and_level_pin_request_flags_q;
      OFS_PERIPH:     rd_mux = peripheral_request_flags_q;
      OFS_EDGE_FLAGS: rd_mux = edge_pin_request_flags_q;
      OFS_EDGE_POL:   rd_mux = edge_pin_polarity_select_q;
      OFS_IRQ_STATUS: rd_mux = {{(DATA_W-EV_W){1'b0}}, irq_status_q};
      OFS_IRQ_MASK:   rd_mux = {{(DATA_W-EV_W){1'b0}}, irq_mask_q};
      default:        rd_mux = '0;
    endcase
  end

  // Data valid only in the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      reg_rdata_q <= '0;
    end else if (bus_req.rd) begin
      reg_rdata_q <= rd_mux;
    end else begin
      reg_rdata_q <= '0;
    end
  end

endmodule // irf_flag_bank

//--- hdl/irf_pkg.sv
package irf_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;

  // ---------------------------------------------------------------
  // Register indices on the register port
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_EDGE_EN    = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_TIMER_LVL  = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_PERIPH     = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_EDGE_FLAGS = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_EDGE_POL   = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK   = 4'h6;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [DATA_W-1:0] RST_EDGE_EN    = 8'h00;
  localparam logic [DATA_W-1:0] RST_TIMER_LVL  = 8'h10;
  localparam logic [DATA_W-1:0] RST_PERIPH     = 8'h00;
  localparam logic [DATA_W-1:0] RST_EDGE_FLAGS = 8'h00;
  localparam logic [DATA_W-1:0] RST_EDGE_POL   = 8'h00;
  localparam logic [3:0]        RST_IRQ        = 4'h0;

  // ---------------------------------------------------------------
  // Field positions, first request register
  // ---------------------------------------------------------------
  localparam int unsigned B_TIMER_B1 = 7;
  localparam int unsigned B_TIMER_A  = 6;
  localparam int unsigned B_RSV_ZERO = 5;
  localparam int unsigned B_RSV_ONE  = 4;
  localparam int unsigned LVL_PINS   = 4;

  // Field positions, second request register
  localparam int unsigned B_DIRECT   = 7;
  localparam int unsigned B_CONV     = 6;
  localparam int unsigned B_SERIAL1  = 4;

  // Writable flag bits of the first and second request registers
  localparam logic [DATA_W-1:0] WMASK_TIMER_LVL = 8'hcf;
  localparam logic [DATA_W-1:0] WMASK_PERIPH    = 8'hd0;

  // Event bits of the interrupt status and mask registers
  localparam int unsigned EV_EDGE   = 0;
  localparam int unsigned EV_TIMER  = 1;
  localparam int unsigned EV_LEVEL  = 2;
  localparam int unsigned EV_PERIPH = 3;
  localparam int unsigned EV_W      = 4;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } irf_bus_req_t;

  typedef struct packed {
    logic timer_b1_wrap;
    logic timer_a_wrap;
    logic direct_sleep;
    logic serial1_done;
  } irf_periph_ev_t;

endpackage : irf_pkg
